// ==== rtl/pwm_time_base_params.svh ====
// Register offsets, field positions, write masks, pin enable values and response codes.
`ifndef PWM_TIME_BASE_PARAMS_SVH
`define PWM_TIME_BASE_PARAMS_SVH
`define OFS_TB_CONTROL    8'h00
`define OFS_TB_COUNT      8'h04
`define OFS_TB_PERIOD     8'h08
`define OFS_EVT_COMPARE   8'h0C
`define OFS_PWM_CTRL_ONE  8'h10
`define OFS_PWM_CTRL_TWO  8'h14
`define OFS_STATUS        8'h18
`define TBC_ENABLE_BIT    15
`define TBC_IDLE_STOP_BIT 13
`define TBC_WMASK         16'hA0FF
`define CT1_WMASK         16'h0FFF
`define CT2_WMASK         16'h0F00
`define CNT_DIR_BIT       15
`define EVC_DIR_BIT       15
`define PIN_EN_ON         8'hFF
`define PIN_EN_OFF        8'h00
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// ==== rtl/pwm_time_base_pkg.sv ====
// Types shared by the time base files.
package pwm_time_base_pkg;
    typedef enum logic [1:0] {
        MODE_FREE   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_UPDN   = 2'b10,
        MODE_UPDN2  = 2'b11
    } tb_mode_t;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_EXEC = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;
endpackage

// ==== rtl/event_postscaler.sv ====
// Divide-by-N postscaler emitting one pulse every Nth input event.
`timescale 1ns/10ps
module event_postscaler #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Control.
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] ratio_m1,
    // Events.
    input  wire logic             event_in,
    output logic                  event_out
);
    logic [WIDTH-1:0] count_q;
    // A clear in the same cycle as an event restarts the count.
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count_q <= '0;
        end else if (event_in) begin
            if (count_q >= ratio_m1) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            event_out <= 1'b0;
        end else begin
            event_out <= event_in && !clear && (count_q >= ratio_m1);
        end
    end
    // Above 1:1 a pulse restarts the count, so it never lasts two cycles.
    chk_pulse_single : assert property (@(posedge clk)
        disable iff (rst) event_out && ratio_m1 != '0 |=> !event_out)
        else $error("postscaler pulse lasted two cycles");
endmodule

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous pin inputs.
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Data.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ==== rtl/motor_pwm_time_base.sv ====
// Motor PWM time base with special event trigger and AXI4-Lite registers.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pwm_time_base_params.svh"
module motor_pwm_time_base
    import pwm_time_base_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read.
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Power state and configuration.
    input  wire logic        CPU_IDLE,
    input  wire logic        CPU_SLEEP,
    input  wire logic        RESET_OUTPUT_STATE_FUSE,
    // Fault pins, active low.
    input  wire logic        FAULT_INPUT_A_N,
    input  wire logic        FAULT_INPUT_B_N,
    // Events.
    output logic             ADC_TRIGGER,
    output logic             TB_EVENT,
    output logic             SINGLE_PULSE_DONE,
    output logic             FAULT_WAKE,
    // PWM pin control: enable is low while the pin is driven.
    output logic [3:0]       PAIR_INDEPENDENT,
    output logic [3:0]       HIGH_PIN_ROUTED,
    output logic [3:0]       LOW_PIN_ROUTED,
    output logic [7:0]       PWM_PIN_OE_N,
    output logic [7:0]       PWM_FORCE_INACTIVE
);
    // Control registers.
    logic [15:0] tbc_q;
    logic [14:0] count_q;
    logic        dir_down_q;
    logic [14:0] period_q;
    logic [15:0] evc_q;
    logic [11:0] ctl1_q;
    logic [3:0]  evt_ops_q;
    logic        fuse_q;
    logic        fuse_taken_q;
    logic        force_inact_q;
    // Derived fields.
    tb_mode_t    mode;
    logic        tb_enable;
    logic        run;
    logic [5:0]  pre_q;
    logic [5:0]  pre_max;
    logic        tick;
    logic        period_match;
    logic        evt_match;
    logic        tb_evt_raw;
    logic        pulse_end;
    logic [1:0]  fault_n_s;
    // Bus write path.
    wr_state_t   wst_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  waddr_q;
    logic [15:0] wdata_q;
    logic [1:0]  wstrb_q;
    logic        wr_do;
    logic [15:0] wmerge;
    logic        wr_tbc, wr_cnt, wr_per, wr_evc, wr_ct1, wr_ct2;
    logic [15:0] rd_word;
    logic        rd_hit;

    assign mode      = tb_mode_t'(tbc_q[1:0]);
    assign tb_enable = tbc_q[`TBC_ENABLE_BIT];
    // Idle only halts the base when the stop bit is set.
    assign run = tb_enable && !(CPU_IDLE && tbc_q[`TBC_IDLE_STOP_BIT]);

    // Prescaler terminal count from 2 bits: 0, 3, 15, 63.
    always_comb begin
        case (tbc_q[3:2])
            2'b00:   pre_max = 6'h00;
            2'b01:   pre_max = 6'h03;
            2'b10:   pre_max = 6'h0F;
            2'b11:   pre_max = 6'h3F;
            default: pre_max = 6'h00;
        endcase
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || !run) begin
            pre_q <= 6'h00;
        end else if (pre_q >= pre_max) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end
    assign tick = run && (pre_q >= pre_max);
    assign period_match = (count_q == period_q);
    assign pulse_end = tick && (mode == MODE_SINGLE) && period_match;

    // Counter and direction.
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            count_q    <= 15'h0000;
            dir_down_q <= 1'b0;
        end else if (wr_cnt) begin
            count_q <= wmerge[14:0];
        end else if (tick) begin
            case (mode)
                MODE_FREE, MODE_SINGLE: begin
                    dir_down_q <= 1'b0;
                    count_q    <= period_match ? 15'h0000
                                               : count_q + 15'h0001;
                end
                MODE_UPDN, MODE_UPDN2: begin
                    if (!dir_down_q && period_match) begin
                        dir_down_q <= 1'b1;
                        count_q    <= count_q - 15'h0001;
                    end else if (dir_down_q && count_q == 15'h0001) begin
                        dir_down_q <= 1'b0;
                        count_q    <= 15'h0000;
                    end else if (dir_down_q) begin
                        count_q <= count_q - 15'h0001;
                    end else begin
                        count_q <= count_q + 15'h0001;
                    end
                end
                default: count_q <= count_q;
            endcase
        end
    end

    // Time base events: period wrap, the bottom in up/down mode, or both ends in double update mode.
    always_comb begin
        case (mode)
            MODE_UPDN:  tb_evt_raw = tick && dir_down_q && count_q == 15'h0001;
            MODE_UPDN2: tb_evt_raw = tick && ((dir_down_q
                            && count_q == 15'h0001) || (!dir_down_q
                            && period_match));
            default:    tb_evt_raw = tick && period_match;
        endcase
    end
    event_postscaler #(.WIDTH(4)) tb_post (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .clear    (1'b0),
        .ratio_m1 (tbc_q[7:4]),
        .event_in (tb_evt_raw),
        .event_out(TB_EVENT)
    );

    // Compare match, qualified by direction only in up/down modes.
    assign evt_match = tick && (evc_q[14:0] == count_q)
        && ((mode == MODE_FREE || mode == MODE_SINGLE)
            || (evc_q[`EVC_DIR_BIT] == dir_down_q));
    event_postscaler #(.WIDTH(4)) evt_post (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .clear    (wr_evc),
        .ratio_m1 (evt_ops_q),
        .event_in (evt_match),
        .event_out(ADC_TRIGGER)
    );

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            SINGLE_PULSE_DONE <= 1'b0;
        end else begin
            SINGLE_PULSE_DONE <= pulse_end;
        end
    end

    // Fault pins come from outside and are synchronised first.
    pin_sync #(.WIDTH(2), .INIT(2'b11)) fault_sync (
        .clk     (CLK_SYS),
        .rst     (SYS_RST),
        .async_in({FAULT_INPUT_B_N, FAULT_INPUT_A_N}),
        .sync_out(fault_n_s)
    );
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            FAULT_WAKE <= 1'b0;
        end else begin
            FAULT_WAKE <= CPU_SLEEP && (fault_n_s != 2'b11);
        end
    end

    // The fuse is sampled on the first clock after reset release.
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            fuse_taken_q <= 1'b0;
            fuse_q       <= 1'b1;
        end else if (!fuse_taken_q) begin
            fuse_taken_q <= 1'b1;
            fuse_q       <= RESET_OUTPUT_STATE_FUSE;
        end
    end

    // Register file with reset and write effects.
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            tbc_q     <= 16'h0000;
            period_q  <= 15'h0000;
            evc_q     <= 16'h0000;
            evt_ops_q <= 4'h0;
            ctl1_q    <= {4'h0, `PIN_EN_OFF};
        end else begin
            if (!fuse_taken_q) begin
                ctl1_q[7:0] <= RESET_OUTPUT_STATE_FUSE ? `PIN_EN_OFF
                                                       : `PIN_EN_ON;
            end else if (wr_ct1) begin
                ctl1_q <= 12'(wmerge & `CT1_WMASK);
            end
            if (wr_tbc) begin
                tbc_q <= wmerge & `TBC_WMASK;
            end else if (pulse_end) begin
                tbc_q[`TBC_ENABLE_BIT] <= 1'b0;
            end
            if (wr_per) begin
                period_q <= wmerge[14:0];
            end
            if (wr_evc) begin
                evc_q <= wmerge;
            end
            if (wr_ct2) begin
                evt_ops_q <= wmerge[11:8];
            end
        end
    end

    // Enabled outputs forced inactive from any reset or end of single pulse.
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            force_inact_q <= 1'b1;
        end else if (pulse_end) begin
            force_inact_q <= 1'b1;
        end else if (tick) begin
            force_inact_q <= 1'b0;
        end
    end
    assign PAIR_INDEPENDENT   = ctl1_q[11:8];
    assign HIGH_PIN_ROUTED    = ctl1_q[7:4];
    assign LOW_PIN_ROUTED     = ctl1_q[3:0];
    assign PWM_PIN_OE_N       = ~ctl1_q[7:0];
    assign PWM_FORCE_INACTIVE = {8{force_inact_q}} & ctl1_q[7:0];

    // AXI4-Lite write: address and data taken in either order.
    assign S_AXI_AWREADY = (wst_q == WR_IDLE) && !aw_got_q;
    assign S_AXI_WREADY  = (wst_q == WR_IDLE) && !w_got_q;
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            wst_q    <= WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            waddr_q  <= 8'h00;
            wdata_q  <= 16'h0000;
            wstrb_q  <= 2'b00;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
        end else begin
            case (wst_q)
                WR_IDLE: begin
                    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                        aw_got_q <= 1'b1;
                        waddr_q  <= S_AXI_AWADDR;
                    end
                    if (S_AXI_WVALID && S_AXI_WREADY) begin
                        w_got_q <= 1'b1;
                        wdata_q <= S_AXI_WDATA[15:0];
                        wstrb_q <= S_AXI_WSTRB[1:0];
                    end
                    if ((aw_got_q || S_AXI_AWVALID)
                        && (w_got_q || S_AXI_WVALID)) begin
                        wst_q <= WR_EXEC;
                    end
                end
                WR_EXEC: begin
                    aw_got_q     <= 1'b0;
                    w_got_q      <= 1'b0;
                    S_AXI_BVALID <= 1'b1;
                    S_AXI_BRESP  <= (waddr_q[7:2] <= 6'h06)
                                    ? `RESP_OKAY : `RESP_SLVERR;
                    wst_q        <= WR_RESP;
                end
                WR_RESP: begin
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        wst_q        <= WR_IDLE;
                    end
                end
                default: wst_q <= WR_IDLE;
            endcase
        end
    end
    assign wr_do  = (wst_q == WR_EXEC);
    assign wr_tbc = wr_do && waddr_q[7:2] == 6'(`OFS_TB_CONTROL >> 2);
    assign wr_cnt = wr_do && waddr_q[7:2] == 6'(`OFS_TB_COUNT >> 2);
    assign wr_per = wr_do && waddr_q[7:2] == 6'(`OFS_TB_PERIOD >> 2);
    assign wr_evc = wr_do && waddr_q[7:2] == 6'(`OFS_EVT_COMPARE >> 2);
    assign wr_ct1 = wr_do && waddr_q[7:2] == 6'(`OFS_PWM_CTRL_ONE >> 2);
    assign wr_ct2 = wr_do && waddr_q[7:2] == 6'(`OFS_PWM_CTRL_TWO >> 2);

    // Merge byte lanes with the current register word.
    always_comb begin
        rd_hit = 1'b1;
        case (waddr_q[7:2])
            6'h00:   rd_word = tbc_q;
            6'h01:   rd_word = {dir_down_q, count_q};
            6'h02:   rd_word = {1'b0, period_q};
            6'h03:   rd_word = evc_q;
            6'h04:   rd_word = {4'h0, ctl1_q};
            6'h05:   rd_word = {4'h0, evt_ops_q, 8'h00};
            default: begin
                rd_word = 16'h0000;
                rd_hit  = 1'b0;
            end
        endcase
        wmerge[7:0]  = wstrb_q[0] ? wdata_q[7:0] : rd_word[7:0];
        wmerge[15:8] = wstrb_q[1] ? wdata_q[15:8] : rd_word[15:8];
    end

    // AXI4-Lite read, one cycle after the address is taken.
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= `RESP_OKAY;
            case (S_AXI_ARADDR[7:2])
                6'h00: S_AXI_RDATA <= {16'h0000, tbc_q};
                6'h01: S_AXI_RDATA <= {16'h0000, dir_down_q, count_q};
                6'h02: S_AXI_RDATA <= {17'h00000, period_q};
                6'h03: S_AXI_RDATA <= {16'h0000, evc_q};
                6'h04: S_AXI_RDATA <= {20'h00000, ctl1_q};
                6'h05: S_AXI_RDATA <= {20'h00000, evt_ops_q, 8'h00};
                6'h06: S_AXI_RDATA <= {29'h00000000, fuse_q, FAULT_WAKE,
                                       force_inact_q};
                default: begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= `RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Checks.
    chk_single_clears_en : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) pulse_end && !wr_tbc |=> !tb_enable)
        else $error("single pulse end left enable set");
    chk_halt_idle : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) CPU_IDLE && tbc_q[13] && !wr_cnt
        |=> $stable(count_q))
        else $error("count moved while halted in idle");
    chk_stop_disabled : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) !tb_enable && !wr_cnt |=> $stable(count_q))
        else $error("count moved while disabled");
    chk_dir_qualify : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) evt_match && mode[1]
        |-> evc_q[15] == dir_down_q)
        else $error("trigger in wrong direction");
    chk_free_nodown : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) tick && !mode[1] && !wr_cnt |=> !dir_down_q)
        else $error("counting down in edge mode");
    chk_wake_fault : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) CPU_SLEEP && fault_n_s == 2'b11
        |=> !FAULT_WAKE)
        else $error("wake without fault");
    // Pins take the fuse level on the first clock after reset release.
    chk_fuse_pins : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) $rose(fuse_taken_q)
        |-> PWM_PIN_OE_N == {8{fuse_q}})
        else $error("pin enables did not follow the fuse");
    chk_per_top_zero : assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST) S_AXI_RVALID
        && $past(S_AXI_ARADDR[7:2]) == 6'h02
        && $rose(S_AXI_RVALID) |-> !S_AXI_RDATA[15])
        else $error("period top bit not zero");
endmodule

// ==== bench/power_stage_model.sv ====
// Far-side model of the power stage fault pins.
`timescale 1ns/10ps
module power_stage_model (
    // Test commands.
    input  wire logic trip_a,
    input  wire logic trip_b,
    // Fault pins, active low.
    output logic      fault_a_n,
    output logic      fault_b_n
);
    // An untripped line is driven high; a trip drives it low.
    assign fault_a_n = ~trip_a;
    assign fault_b_n = ~trip_b;
endmodule

// ==== bench/test_motor_pwm_time_base.sv ====
// Self-checking bench for the motor PWM time base.
`timescale 1ns/10ps
`include "pwm_time_base_params.svh"
module test_motor_pwm_time_base import pwm_time_base_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, idle = 1'b0, slp = 1'b0;
    logic        fuse = 1'b1, ta = 1'b0, tpb = 1'b0, arv = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, rry = 1'b0;
    logic [7:0]  aw = 8'h00, ar = 8'h00, oen, fin;
    logic [31:0] wd = 32'h0000_0000, rdd;
    logic        awr, wrd, bv, arr, rv, fa_n, fb_n, adc, tbe, spd, wake;
    logic [1:0]  br, rr;
    logic [3:0]  pim, hpe, lpe;
    int          err_count = 0, num_checks = 0, p, c;
    localparam logic [7:0] RA [6] = '{`OFS_TB_COUNT, `OFS_TB_PERIOD,
        `OFS_EVT_COMPARE, `OFS_PWM_CTRL_ONE, `OFS_PWM_CTRL_TWO,
        `OFS_TB_CONTROL};
    localparam logic [15:0] RE [6] = '{16'h7FFF, 16'h7FFF, 16'hFFFF,
        16'h0FFF, 16'h0F00, 16'hA0FF};
    localparam logic [3:0] FW [4] = '{4'hE, 4'hD, 4'h3, 4'h4};
    always #5 clk = ~clk;
    motor_pwm_time_base DUT (
        .CLK_SYS(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .CPU_IDLE(idle),
        .CPU_SLEEP(slp), .RESET_OUTPUT_STATE_FUSE(fuse),
        .FAULT_INPUT_A_N(fa_n), .FAULT_INPUT_B_N(fb_n),
        .ADC_TRIGGER(adc), .TB_EVENT(tbe), .SINGLE_PULSE_DONE(spd),
        .FAULT_WAKE(wake), .PAIR_INDEPENDENT(pim), .HIGH_PIN_ROUTED(hpe),
        .LOW_PIN_ROUTED(lpe), .PWM_PIN_OE_N(oen), .PWM_FORCE_INACTIVE(fin)
    );
    power_stage_model stage (.trip_a(ta), .trip_b(tpb),
        .fault_a_n(fa_n), .fault_b_n(fb_n));
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic die();
        err_count++;
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge clk);
        aw <= a;
        wd <= {16'h0000, d};
        {awv, wv, bry} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wrd === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        bry <= 1'b0;
        chk({30'h0, br}, {30'h0, er});
        if (n >= 50) die();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        int n;
        @(posedge clk);
        ar <= a;
        {arv, rry} <= 2'h3;
        for (n = 0; n < 50 && rv !== 1'b1; n++) begin
            @(posedge clk);
            if (arv && arr === 1'b1) arv <= 1'b0;
        end
        rry <= 1'b0;
        chk(rdd, e);
        chk({30'h0, rr}, {30'h0, er});
        if (n >= 50) die();
    endtask
    task automatic do_reset(input logic f);
        fuse <= f;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic pv(input int s);
        return s == 0 ? tbe : adc;
    endfunction
    // Gap in cycles from a pulse of one event to the next pulse of the same or another event.
    task automatic span(input int a, input int b, output int g);
        int n;
        for (n = 0; n < 9000 && pv(a) !== 1'b1; n++) @(posedge clk);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (pv(b) !== 1'b1 && g < 9000);
        if (n >= 9000 || g >= 9000) die();
    endtask
    task automatic cnt(output int k);
        k = 0;
        repeat (200) begin
            @(posedge clk);
            if (tbe === 1'b1) k++;
        end
    endtask
    task automatic dirpair(input logic [15:0] ctl, output int d0, d1);
        wr(`OFS_TB_CONTROL, ctl, `RESP_OKAY);
        wr(`OFS_EVT_COMPARE, 16'(c), `RESP_OKAY);
        span(0, 1, d0);
        wr(`OFS_EVT_COMPARE, 16'h8000 | 16'(c), `RESP_OKAY);
        span(0, 1, d1);
    endtask
    initial begin
        int s, g, t0, d0, d1, k;
        logic [31:0] v;
        v = $urandom(32'hCC9C);
        do_reset(1'b1);
        chk({24'h0, oen}, 32'h0000_00FF);
        rdc(`OFS_PWM_CTRL_ONE, 32'h0, `RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(RA[i], 16'hFFFF, `RESP_OKAY);
            rdc(RA[i], {16'h0000, RE[i]}, `RESP_OKAY);
        end
        wr(8'h1C, 16'hFFFF, `RESP_SLVERR);
        rdc(8'h1C, 32'h0, `RESP_SLVERR);
        repeat (4) begin
            v = $urandom;
            wr(`OFS_PWM_CTRL_ONE, v[15:0], `RESP_OKAY);
            chk({pim, hpe, lpe}, {20'h0, v[11:0]});
            chk({24'h0, oen}, {24'h0, ~v[7:0]});
        end
        p = 8 + $urandom % 24;
        c = p / 2;
        wr(`OFS_TB_CONTROL, 16'h0000, `RESP_OKAY);
        wr(`OFS_TB_PERIOD, 16'(p), `RESP_OKAY);
        wr(`OFS_EVT_COMPARE, 16'(c), `RESP_OKAY);
        wr(`OFS_PWM_CTRL_TWO, 16'h0000, `RESP_OKAY);
        wr(`OFS_TB_COUNT, 16'h0000, `RESP_OKAY);
        wr(`OFS_TB_CONTROL, 16'h8000, `RESP_OKAY);
        span(0, 0, t0);
        chk(t0, p + 1);
        for (k = 1; k < 4; k++) begin
            wr(`OFS_TB_CONTROL, 16'h8000 | 16'(k << 2), `RESP_OKAY);
            span(0, 0, g);
            span(0, 0, g);
            chk(g, t0 << (2 * k));
        end
        for (int i = 0; i < 3; i++) begin
            s = i == 0 ? 0 : i == 1 ? 15 : $urandom % 16;
            wr(`OFS_PWM_CTRL_TWO, 16'(s << 8), `RESP_OKAY);
            wr(`OFS_TB_CONTROL, 16'h8000 | 16'(s << 4), `RESP_OKAY);
            span(0, 0, g);
            span(0, 0, g);
            chk(g, (s + 1) * t0);
            span(1, 1, g);
            span(1, 1, g);
            chk(g, (s + 1) * t0);
        end
        wr(`OFS_PWM_CTRL_TWO, 16'h0300, `RESP_OKAY);
        span(1, 1, g);
        repeat (2 * t0) @(posedge clk);
        wr(`OFS_EVT_COMPARE, 16'(c), `RESP_OKAY);
        for (k = 0; k < 9000 && adc !== 1'b1; k++) @(posedge clk);
        chk({31'h0, k > 3 * t0 && k < 9000}, 32'h1);
        wr(`OFS_PWM_CTRL_TWO, 16'h0000, `RESP_OKAY);
        dirpair(16'h8000, d0, d1);
        chk(d1, d0);
        dirpair(16'h8002, d0, d1);
        span(0, 0, g);
        chk({31'h0, d0 < g / 2 && d1 > g / 2}, 32'h1);
        wr(`OFS_TB_CONTROL, 16'h8003, `RESP_OKAY);
        span(1, 1, k);
        span(1, 1, k);
        chk(k, g);
        span(0, 0, k);
        span(0, 0, s);
        chk(k + s, g);
        idle <= 1'b1;
        wr(`OFS_TB_CONTROL, 16'hA000, `RESP_OKAY);
        cnt(k);
        chk(k, 0);
        wr(`OFS_TB_CONTROL, 16'h8000, `RESP_OKAY);
        cnt(k);
        chk({31'h0, k > 0}, 32'h1);
        idle <= 1'b0;
        wr(`OFS_TB_CONTROL, 16'h0000, `RESP_OKAY);
        cnt(k);
        chk(k, 0);
        wr(`OFS_TB_COUNT, 16'h0000, `RESP_OKAY);
        wr(`OFS_TB_PERIOD, 16'h0028, `RESP_OKAY);
        wr(`OFS_TB_CONTROL, 16'h8001, `RESP_OKAY);
        for (k = 0; k < 500 && spd !== 1'b1; k++) @(posedge clk);
        chk({31'h0, k < 500}, 32'h1);
        rdc(`OFS_TB_CONTROL, 32'h0000_0001, `RESP_OKAY);
        rdc(`OFS_TB_COUNT, 32'h0, `RESP_OKAY);
        chk({24'h0, fin}, {24'h0, hpe, lpe});
        for (int i = 0; i < 4; i++) begin
            {slp, ta, tpb} <= FW[i][2:0];
            repeat (5) @(posedge clk);
            chk({31'h0, wake}, {31'h0, FW[i][3]});
        end
        do_reset(1'b0);
        chk({24'h0, oen}, 32'h0);
        chk({24'h0, fin}, 32'h0000_00FF);
        rdc(`OFS_PWM_CTRL_ONE, 32'h0000_00FF, `RESP_OKAY);
        wrap_up();
    end
endmodule
